// ### rtl/caw_pkg.sv
// Shared constants and types for the counter array watchdog
package caw_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'hd8;
  localparam logic [7:0] ADDR_MODE   = 8'hd9;
  localparam logic [7:0] ADDR_CNT_LO = 8'hf9;
  localparam logic [7:0] ADDR_CNT_HI = 8'hfa;
  localparam logic [7:0] ADDR_OFFSET = 8'hfb;
  localparam logic [7:0] ADDR_UPDATE = 8'hfc;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_OVF_BIT = 7;
  localparam int unsigned CTRL_RUN_BIT = 6;
  localparam int unsigned CTRL_WD_FLAG = 5;
  localparam int unsigned NUM_MODULES  = 6;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  MODE_RESET   = 8'h40;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_FULL    = 8'hff;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] CNT_FULL     = 16'hffff;

  // ----------------------------------------------------------------------
  // Counter clock selections and divide counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] CSEL_DIV12 = 3'h0;
  localparam logic [2:0] CSEL_DIV4  = 3'h1;
  localparam logic [2:0] CSEL_T0    = 3'h2;
  localparam logic [2:0] CSEL_EXT   = 3'h3;
  localparam logic [2:0] CSEL_SYS   = 3'h4;
  localparam logic [2:0] CSEL_EXT8  = 3'h5;
  localparam logic [3:0] DIV12_LIM  = 4'hb;
  localparam logic [3:0] DIV4_LIM   = 4'h3;
  localparam logic [3:0] DIV8_LIM   = 4'h7;
  localparam logic [3:0] DIV1_LIM   = 4'h0;

  // Default expiry: 256 counter ticks, 3072 system clocks
  localparam int unsigned WD_DEFAULT_TICKS = 256;
  localparam int unsigned WD_DEFAULT_CLKS  = WD_DEFAULT_TICKS * (int'(DIV12_LIM) + 1);

  // Mode register layout
  typedef struct packed {
    logic       idle_suspend;
    logic       wd_enable;
    logic       wd_lock;
    logic       rsvd;
    logic [2:0] clk_sel;
    logic       ovf_irq_en;
  } caw_mode_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caw_sfr_req_t;

endpackage : caw_pkg

// ### rtl/caw_prescaler.sv
// Counter clock tick generator for the counter array
`timescale 1ns/1ps
`default_nettype none

module caw_prescaler
  import caw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Source selection and sources
  input  wire logic [2:0] clk_sel,
  input  wire logic       timer0_ovf,
  input  wire logic       ext_clk_pin,
  // Counter tick
  output logic            tick
);

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  logic [3:0] div_q;
  logic [2:0] ext_sync_q;
  logic       src_pulse;
  logic [3:0] limit;

  function automatic logic [3:0] div_limit(input logic [2:0] sel);
    case (sel)
      CSEL_DIV12: div_limit = DIV12_LIM;
      CSEL_DIV4:  div_limit = DIV4_LIM;
      CSEL_EXT8:  div_limit = DIV8_LIM;
      default:    div_limit = DIV1_LIM;
    endcase
  endfunction : div_limit

  // Pin is asynchronous: two stages, then an edge stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin};
    end
  end

  // Source pulse per selection
  always_comb begin
    case (clk_sel)
      CSEL_T0:   src_pulse = timer0_ovf;
      CSEL_EXT,
      CSEL_EXT8: src_pulse = ext_sync_q[1] & ~ext_sync_q[2];
      default:   src_pulse = 1'b1;
    endcase
  end

  assign limit = div_limit(clk_sel);
  assign tick  = src_pulse & (div_q >= limit); // see RL8

  // Greater-or-equal keeps a source switch from running past the limit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= 4'h0;
    end else if (src_pulse) begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] gap_q;
  logic       seen_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= tick ? 8'h00 : gap_q + 8'h01;
      seen_q <= (clk_sel == CSEL_DIV12) & (seen_q | tick);
    end
  end

  AST_DIV12_SPACING: assert property (@(posedge clk) disable iff (sys_rst) // see RL9
    (tick && seen_q && clk_sel == CSEL_DIV12 && $past(clk_sel) == CSEL_DIV12)
      |-> gap_q == {4'h0, DIV12_LIM})
    else $error("divide-by-12 tick spacing wrong");

endmodule : caw_prescaler

`default_nettype wire

// ### rtl/caw_watchdog.sv
// Counter array control, 16-bit counter and watchdog module
//
// Operation
// RL1: Reset the system when low byte overflows while update byte equals high byte.
// RL2: Writing 1 to the watchdog match flag while enabled forces a reset.
// RL3: While enabled, clock select and idle suspend bits stay frozen.
// RL4: Setting enable bit or lock bit enables the watchdog.
// RL5: Lock bit keeps the watchdog enabled until the next system reset.
// RL6: With lock clear, clearing enable bit disables the watchdog.
// RL7: Every reset leaves the watchdog enabled.
// RL8: Reset defaults: clock divided by 12, low byte and offset byte zero.
// RL9: Default expiry is 256 counter ticks, 3072 system clocks.
// RL10: Software disables, configures, enables, then writes the update byte.
// RL11: Idle suspend bit stops watchdog timing while the processor idles.
// RL12: Overflow flag set when the counter rolls from all ones to zero.
// RL13: Overflow flag requests interrupt when enabled; only software clears it.
// RL14: Six match flags set by hardware, request interrupt, cleared by software; the watchdog flag is not set by hardware while enabled.
// RL15: Run bit stops the counter at 0, lets it count at 1.
// RL16: Any update byte write loads counter high byte plus offset byte.
// RL17: While enabled the counter runs regardless of the run bit.
// RL18: While enabled, writes to counter low and high bytes are ignored.
// RL19: Counter advances once per tick, low byte carrying into high byte.
`timescale 1ns/1ps
`default_nettype none

module caw_watchdog
  import caw_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire caw_sfr_req_t           sfr_req,
  output logic [7:0]                  sfr_rdata,
  // System context
  input  wire logic                   cpu_idle,
  input  wire logic                   timer0_ovf,
  input  wire logic                   ext_clk_pin,
  // Other compare modules
  input  wire logic [NUM_MODULES-1:0] module_match_evt,
  input  wire logic [NUM_MODULES-1:0] module_irq_en,
  // Results
  output logic                        wdt_reset,
  output logic                        counter_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  caw_mode_t                mode_q;
  logic                     ovf_flag_q;
  logic                     run_q;
  logic [NUM_MODULES-1:0]   match_q;
  logic [15:0]              cnt_q;
  logic [7:0]               offset_q;
  logic [7:0]               update_q;
  logic                     wdt_reset_q;
  logic [7:0]               rdata_q;
  logic                     wd_en;
  logic                     tick;
  logic                     advance;
  logic                     wd_expire;
  logic                     wd_force;
  caw_mode_t                mode_wr;

  function automatic logic wr_at(input caw_sfr_req_t r, input logic [7:0] a);
    wr_at = r.wr & (r.addr == a);
  endfunction : wr_at

  assign mode_wr = caw_mode_t'(sfr_req.wdata);
  assign wd_en   = mode_q.wd_enable | mode_q.wd_lock; // see RL4

  // ----------------------------------------------------------------------
  // Counter clock and advance
  // ----------------------------------------------------------------------
  caw_prescaler i_caw_prescaler (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_sel     (mode_q.clk_sel),
    .timer0_ovf  (timer0_ovf),
    .ext_clk_pin (ext_clk_pin),
    .tick        (tick)
  );

  // Watchdog forces the counter on; idle suspend pauses it
  assign advance = tick & (run_q | wd_en) // see RL15 see RL17
                 & ~(mode_q.idle_suspend & cpu_idle); // see RL11

  assign wd_expire = wd_en & advance & (cnt_q[7:0] == BYTE_FULL)
                   & (update_q == cnt_q[15:8]); // see RL1
  assign wd_force  = wd_en & wr_at(sfr_req, ADDR_CTRL)
                   & sfr_req.wdata[CTRL_WD_FLAG]; // see RL2

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  // Lock is sticky and only sys_rst releases it, so enable cannot drop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= caw_mode_t'(MODE_RESET); // see RL7 see RL8
    end else if (wr_at(sfr_req, ADDR_MODE)) begin
      mode_q.wd_lock    <= mode_q.wd_lock | mode_wr.wd_lock; // see RL5
      mode_q.wd_enable  <= mode_wr.wd_enable | mode_q.wd_lock; // see RL6
      mode_q.ovf_irq_en <= mode_wr.ovf_irq_en;
      if (!wd_en) begin
        mode_q.idle_suspend <= mode_wr.idle_suspend; // see RL3
        mode_q.clk_sel      <= mode_wr.clk_sel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register: flags and run bit
  // ----------------------------------------------------------------------
  // Hardware set beats a same-cycle software clear, so no event is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovf_flag_q <= CTRL_RESET[CTRL_OVF_BIT];
    end else if (advance && cnt_q == CNT_FULL) begin
      ovf_flag_q <= 1'b1; // see RL12
    end else if (wr_at(sfr_req, ADDR_CTRL)) begin
      ovf_flag_q <= sfr_req.wdata[CTRL_OVF_BIT]; // see RL13
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= CTRL_RESET[CTRL_RUN_BIT];
    end else if (wr_at(sfr_req, ADDR_CTRL)) begin
      run_q <= sfr_req.wdata[CTRL_RUN_BIT];
    end
  end

  // A forcing write to the watchdog flag is not stored as a flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      match_q <= CTRL_RESET[NUM_MODULES-1:0];
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (module_match_evt[i] && !(i == CTRL_WD_FLAG && wd_en)) begin
          match_q[i] <= 1'b1; // see RL14
        end else if (wr_at(sfr_req, ADDR_CTRL)) begin
          match_q[i] <= sfr_req.wdata[i] & ~(i == CTRL_WD_FLAG && wd_en);
        end
      end
    end
  end

  assign counter_irq = (ovf_flag_q & mode_q.ovf_irq_en) // see RL13
                     | (|(match_q & module_irq_en)); // see RL14

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= CNT_RESET; // see RL8
    end else if (wr_at(sfr_req, ADDR_CNT_LO) && !wd_en) begin
      cnt_q[7:0] <= sfr_req.wdata; // see RL18
    end else if (wr_at(sfr_req, ADDR_CNT_HI) && !wd_en) begin
      cnt_q[15:8] <= sfr_req.wdata;
    end else if (advance) begin
      cnt_q <= cnt_q + 16'h0001; // see RL19
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog compare bytes and reset output
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_q <= BYTE_ZERO; // see RL8
    end else if (wr_at(sfr_req, ADDR_OFFSET)) begin
      offset_q <= sfr_req.wdata;
    end
  end

  // Written data is discarded: the reload is always counter high byte plus offset byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      update_q <= BYTE_ZERO; // see RL9
    end else if (wr_at(sfr_req, ADDR_UPDATE)) begin
      update_q <= cnt_q[15:8] + offset_q; // see RL16
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_reset_q <= 1'b0;
    end else begin
      wdt_reset_q <= wd_expire | wd_force; // see RL1 see RL2
    end
  end

  assign wdt_reset = wdt_reset_q;

  // ----------------------------------------------------------------------
  // Read data, one cycle after the read strobe; unmapped reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= BYTE_ZERO;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        ADDR_CTRL:   rdata_q <= {ovf_flag_q, run_q, match_q};
        ADDR_MODE:   rdata_q <= {mode_q.idle_suspend, mode_q.wd_enable, mode_q.wd_lock,
                                 1'b0, mode_q.clk_sel, mode_q.ovf_irq_en};
        ADDR_CNT_LO: rdata_q <= cnt_q[7:0];
        ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
        ADDR_OFFSET: rdata_q <= offset_q;
        ADDR_UPDATE: rdata_q <= update_q;
        default:     rdata_q <= BYTE_ZERO;
      endcase
    end
  end

  assign sfr_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_EXPIRE_RESET: assert property (@(posedge clk) disable iff (sys_rst) // see RL1
    (wd_en && advance && cnt_q[7:0] == BYTE_FULL && update_q == cnt_q[15:8]) |=> wdt_reset)
    else $error("expiry did not reset");

  AST_FORCE_RESET: assert property (@(posedge clk) disable iff (sys_rst) // see RL2
    (wd_en && sfr_req.wr && sfr_req.addr == ADDR_CTRL && sfr_req.wdata[CTRL_WD_FLAG])
      |=> wdt_reset && !match_q[CTRL_WD_FLAG])
    else $error("forced reset missing");

  AST_FROZEN_MODE: assert property (@(posedge clk) disable iff (sys_rst) // see RL3
    wd_en |=> $stable(mode_q.clk_sel) && $stable(mode_q.idle_suspend))
    else $error("frozen mode bits changed");

  AST_ENABLE_SET: assert property (@(posedge clk) disable iff (sys_rst) // see RL4
    (sfr_req.wr && sfr_req.addr == ADDR_MODE && (mode_wr.wd_enable || mode_wr.wd_lock))
      |=> wd_en)
    else $error("enable write ignored");

  AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (sys_rst) // see RL5
    mode_q.wd_lock |=> mode_q.wd_lock && wd_en)
    else $error("locked watchdog released");

  AST_DISABLE: assert property (@(posedge clk) disable iff (sys_rst) // see RL6
    (!mode_q.wd_lock && sfr_req.wr && sfr_req.addr == ADDR_MODE
      && !mode_wr.wd_enable && !mode_wr.wd_lock) |=> !wd_en)
    else $error("disable write ignored");

  AST_RESET_ENABLED: assert property (@(posedge clk) // see RL7
    $past(sys_rst) |-> wd_en && !mode_q.wd_lock && cnt_q == CNT_RESET)
    else $error("not enabled after reset");

  AST_UPDATE_LOAD: assert property (@(posedge clk) disable iff (sys_rst) // see RL16
    (sfr_req.wr && sfr_req.addr == ADDR_UPDATE)
      |=> update_q == $past(cnt_q[15:8]) + $past(offset_q))
    else $error("update byte load wrong");

  AST_OVF_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // see RL12
    (advance && cnt_q == CNT_FULL) |=> ovf_flag_q && cnt_q == CNT_RESET)
    else $error("overflow flag not set");

  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // see RL13
    (ovf_flag_q && !(sfr_req.wr && sfr_req.addr == ADDR_CTRL)) |=> ovf_flag_q)
    else $error("overflow flag cleared by hardware");

  AST_FORCED_RUN: assert property (@(posedge clk) disable iff (sys_rst) // see RL17
    (wd_en && advance) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter not forced on");

  AST_STOPPED: assert property (@(posedge clk) disable iff (sys_rst) // see RL15
    (!run_q && !wd_en && !sfr_req.wr) |=> $stable(cnt_q))
    else $error("stopped counter moved");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // see RL11
    (wd_en && mode_q.idle_suspend && cpu_idle) |=> $stable(cnt_q) && !wdt_reset)
    else $error("idle did not suspend timing");

  AST_NO_CNT_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // see RL18
    (wd_en && !advance && sfr_req.wr
      && (sfr_req.addr == ADDR_CNT_LO || sfr_req.addr == ADDR_CNT_HI)) |=> $stable(cnt_q))
    else $error("counter written while enabled");

endmodule : caw_watchdog

`default_nettype wire

// ### testbench/test_counter_array_watchdog.sv
// Self-checking testbench for the counter array watchdog
`timescale 1ns/1ps
`default_nettype none

module test_counter_array_watchdog;
  import caw_pkg::*;

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic                   clk;
  logic                   sys_rst;
  caw_sfr_req_t           sfr_req;
  logic [7:0]             sfr_rdata;
  logic                   cpu_idle;
  logic                   timer0_ovf;
  logic                   ext_clk_pin;
  logic [NUM_MODULES-1:0] module_match_evt;
  logic [NUM_MODULES-1:0] module_irq_en;
  logic                   wdt_reset;
  logic                   counter_irq;
  int                     error_cnt;
  int                     compares;
  int                     pulses;
  int                     n;
  int                     p0;
  logic [7:0]             v;

  caw_watchdog i_caw_watchdog (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .sfr_req          (sfr_req),
    .sfr_rdata        (sfr_rdata),
    .cpu_idle         (cpu_idle),
    .timer0_ovf       (timer0_ovf),
    .ext_clk_pin      (ext_clk_pin),
    .module_match_evt (module_match_evt),
    .module_irq_en    (module_irq_en),
    .wdt_reset        (wdt_reset),
    .counter_irq      (counter_irq)
  );

  // 10 MHz system clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Count every reset pulse so short pulses inside bus tasks are not missed
  always @(posedge clk) begin
    if (wdt_reset === 1'b1) pulses <= pulses + 1;
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // All tasks start and end 10 ns after a rising edge
  task cyc(input int c);
    repeat (c) begin
      @(posedge clk);
      #10;
    end
  endtask : cyc

  // Hold one idle cycle after each strobe so no signal is set twice at once
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    sfr_req.wr = 1'b0;
    cyc(1);
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    sfr_req.rd = 1'b0;
    d = sfr_rdata;
    cyc(1);
  endtask : rd

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : chk

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  // Bounded wait for the watchdog reset request, c holds cycles waited
  task wait_rst(input int lim, output int c);
    c = 0;
    while (wdt_reset !== 1'b1 && c < lim) begin
      cyc(1);
      c++;
    end
  endtask : wait_rst

  task do_reset;
    sys_rst = 1'b1;
    cyc(16);
    sys_rst = 1'b0;
  endtask : do_reset

  task end_sim;
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Hang guard, well beyond the roughly 5100 cycles the tests need
  initial begin
    #3_000_000;
    error_cnt++;
    end_sim();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    error_cnt        = 0;
    compares         = 0;
    pulses           = 0;
    sys_rst          = 1'b1;
    sfr_req          = '0;
    cpu_idle         = 1'b0;
    timer0_ovf       = 1'b0;
    ext_clk_pin      = 1'b0;
    module_match_evt = '0;
    module_irq_en    = '0;
    #10;
    do_reset();
    // Untouched defaults expire after 256 ticks of clk/12
    wait_rst(3200, n);
    chk(16'(n), 16'(WD_DEFAULT_CLKS));
    cyc(1);
    chk({15'h0, wdt_reset}, 16'h0000);
    rd_chk(ADDR_CNT_HI, 8'h01);
    // Second reset restores every default
    do_reset();
    rd_chk(ADDR_CNT_LO, BYTE_ZERO);
    rd_chk(ADDR_CTRL, CTRL_RESET);
    rd_chk(ADDR_MODE, MODE_RESET);
    rd_chk(ADDR_OFFSET, BYTE_ZERO);
    rd_chk(8'h00, 8'h00);
    // Enabled: clock select, idle bit and counter writes are refused
    wr(ADDR_MODE, 8'hc8);
    rd_chk(ADDR_MODE, MODE_RESET);
    wr(ADDR_CNT_LO, 8'h55);
    rd(ADDR_CNT_LO, v);
    chk({15'h0, v != 8'h55}, 16'h0001);
    // Disable first, then the clock select may change
    wr(ADDR_MODE, 8'h00);
    rd_chk(ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h08);
    rd_chk(ADDR_MODE, 8'h08);
    // Run bit low holds the counter still
    wr(ADDR_CNT_LO, 8'h12);
    cyc(20);
    rd_chk(ADDR_CNT_LO, 8'h12);
    // Roll over from all ones at the system clock rate
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h40);
    cyc(20);
    rd_chk(ADDR_CTRL, 8'hc0);
    chk({15'h0, counter_irq}, 16'h0000);
    wr(ADDR_MODE, 8'h09);
    chk({15'h0, counter_irq}, 16'h0001);
    cyc(10);
    rd_chk(ADDR_CTRL, 8'hc0);
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_CTRL, 8'h00);
    chk({15'h0, counter_irq}, 16'h0000);
    wr(ADDR_MODE, 8'h08);
    // Each match flag sticks, interrupts, and clears by software only
    for (int i = 0; i < NUM_MODULES; i++) begin
      module_irq_en    = 6'h01 << i;
      module_match_evt = 6'h01 << i;
      cyc(1);
      module_match_evt = '0;
      cyc(3);
      rd_chk(ADDR_CTRL, 8'h01 << i);
      chk({15'h0, counter_irq}, 16'h0001);
      wr(ADDR_CTRL, 8'h00);
      chk({15'h0, counter_irq}, 16'h0000);
    end
    module_irq_en = '0;
    // Timer overflow pulses, then pin edges, as counter clocks with run high
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    repeat (5) begin
      timer0_ovf = 1'b1;
      cyc(1);
      timer0_ovf = 1'b0;
      cyc(2);
    end
    rd_chk(ADDR_CNT_LO, 8'h05);
    wr(ADDR_MODE, 8'h06);
    repeat (3) begin
      ext_clk_pin = 1'b1;
      cyc(3);
      ext_clk_pin = 1'b0;
      cyc(3);
    end
    rd_chk(ADDR_CNT_LO, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    // Configure in the documented order with idle suspend, offset 2
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h10);
    wr(ADDR_OFFSET, 8'h02);
    wr(ADDR_MODE, 8'h88);
    cpu_idle = 1'b1;
    wr(ADDR_MODE, 8'hc8);
    rd_chk(ADDR_MODE, 8'hc8);
    wr(ADDR_UPDATE, 8'h77);
    rd_chk(ADDR_UPDATE, 8'h12);
    p0 = pulses;
    cyc(1000);
    chk(16'(pulses - p0), 16'h0000);
    cpu_idle = 1'b0;
    // 2 * 256 + 256 ticks with run bit low; counter forced on
    wait_rst(900, n);
    chk(16'(n), 16'h0300);
    // Pulse stands one cycle; let its count settle before the forced reset
    cyc(1);
    chk({15'h0, wdt_reset}, 16'h0000);
    // Software forced reset; the flag itself stays clear
    p0 = pulses;
    wr(ADDR_CTRL, 8'h20);
    chk(16'(pulses - p0), 16'h0001);
    rd_chk(ADDR_CTRL, 8'h00);
    // Lock bit enables and cannot be undone short of a reset
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_MODE, 8'h28);
    // Lock alone keeps the enable bit as written; the next write forces it on
    rd_chk(ADDR_MODE, 8'h28);
    wr(ADDR_MODE, 8'h08);
    rd_chk(ADDR_MODE, 8'h68);
    do_reset();
    rd_chk(ADDR_MODE, MODE_RESET);
    end_sim();
  end

endmodule : test_counter_array_watchdog

`default_nettype wire
